// ==== src/rtac_consts.vh ====
`ifndef RTAC_CONSTS_VH
`define RTAC_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RTAC_OFF_CH_RESET     8'h00
`define RTAC_OFF_EMPHASIS     8'h15
`define RTAC_OFF_SWING        8'h2d
`define RTAC_OFF_ADAPT_CTRL   8'h2f
`define RTAC_OFF_START_IDX    8'h39
`define RTAC_OFF_TABLE_FIRST  8'h40
`define RTAC_OFF_TABLE_LAST   8'h5f
`define RTAC_OFF_CHAN_SELECT  8'hff

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RTAC_BIT_CH_RESET     2
`define RTAC_BIT_OVERRIDE     3
`define RTAC_BIT_RANGE        6
`define RTAC_BIT_CHAN_REGS    2
`define RTAC_BIT_BROADCAST    3
`define RTAC_IDX_MSB          4
`define RTAC_CODE_MSB         2
`define RTAC_SEL_MSB          1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RTAC_RST_BYTE         8'h00
`define RTAC_RST_IDX          5'h00

// ----------------------------------------
// Decoded level tables
// ----------------------------------------
// Swing in tens of millivolts: 60 + 10*code
`define RTAC_SWING_BASE       8'h3c
`define RTAC_SWING_STEP       8'h0a
// De-emphasis magnitude in tenths of dB, range set then range clear
`define RTAC_DEM_HI_TABLE  56'h82_5f_50_41_32_23_0f
`define RTAC_DEM_LO_TABLE  56'h96_6e_5a_48_3c_2a_14

`endif

// ==== src/rtac_channel_config.v ====
`timescale 1ns/10ps
// Contract
// RULE1: Bit 3 of 0x2f enables index override
// RULE2: Override index from 0x39 bits 4:0
// RULE3: Index n selects table register 0x40+n
// RULE4: Index zero starts at entry 0x40
// RULE5: Swing code n gives 0.6V plus n*0.1V
// RULE6: De-emphasis from 0x15 bits 2:0, bit 6
// RULE7: Fifteen levels; code 000 gives 0 dB
// RULE8: Range bit picks the two level sets
// RULE9: Shared select register plus per-channel sets
// RULE10: Host changes partial fields by read-modify-write
// RULE11: Host leaves unlisted registers unwritten
// RULE12: Bit 2 of 0x00 resets channel registers
// RULE13: Select field 0xff bits 1:0 routes accesses
// RULE14: 0xff bits 3 and 2 broadcast writes
// RULE15: Decoded levels held as static outputs
`include "rtac_consts.vh"

module rtac_channel_config #(
    parameter NUM_CH = 4
) (
    input  wire                clk_sys,      // Register clock, 25 MHz
    input  wire                reset_n,      // Synchronous reset, active low
    input  wire                reg_wr,       // Write strobe, one cycle
    input  wire                reg_rd,       // Read strobe, one cycle
    input  wire [7:0]          reg_addr,     // Register offset
    input  wire [7:0]          reg_wdata,    // Write data
    output reg  [7:0]          reg_rdata,    // Read data, valid after read
    output reg  [5*NUM_CH-1:0] start_index,  // Adaptation start index
    output reg  [8*NUM_CH-1:0] start_boost,  // Table entry at start index
    output reg  [8*NUM_CH-1:0] swing_level,  // Swing, tens of mV
    output reg  [8*NUM_CH-1:0] deemph_level  // De-emphasis, tenths of -dB
);

    // ----------------------------------------
    // Default candidate boost table
    // ----------------------------------------
    function [7:0] boost_default;
        input [4:0] idx;
        begin
            case (idx)
                5'h00: boost_default = 8'h00;
                5'h01: boost_default = 8'h01;
                5'h02: boost_default = 8'h04;
                5'h03: boost_default = 8'h10;
                5'h04: boost_default = 8'h40;
                5'h05: boost_default = 8'h08;
                5'h06: boost_default = 8'h02;
                5'h07: boost_default = 8'h80;
                5'h08: boost_default = 8'h03;
                5'h09: boost_default = 8'h0c;
                5'h0a: boost_default = 8'h30;
                5'h0b: boost_default = 8'h41;
                5'h0c: boost_default = 8'h50;
                5'h0d: boost_default = 8'hc0;
                5'h0e: boost_default = 8'h60;
                5'h0f: boost_default = 8'h90;
                5'h10: boost_default = 8'h88;
                5'h11: boost_default = 8'h82;
                5'h12: boost_default = 8'ha0;
                5'h13: boost_default = 8'h46;
                5'h14: boost_default = 8'h52;
                5'h15: boost_default = 8'h8c;
                5'h16: boost_default = 8'hb0;
                5'h17: boost_default = 8'hc8;
                5'h18: boost_default = 8'h57;
                5'h19: boost_default = 8'h5d;
                5'h1a: boost_default = 8'h69;
                5'h1b: boost_default = 8'h75;
                5'h1c: boost_default = 8'hd5;
                5'h1d: boost_default = 8'h99;
                5'h1e: boost_default = 8'h96;
                default: boost_default = 8'ha5;
            endcase
        end
    endfunction

    // De-emphasis decode, 0 for code 000
    function [7:0] deemph_decode;
        input [7:0] ctrl;
        reg   [2:0] code;
        reg   [55:0] tab;
        begin
            code = ctrl[`RTAC_CODE_MSB:0];
            tab  = ctrl[`RTAC_BIT_RANGE] ? `RTAC_DEM_HI_TABLE // see RULE8
                                         : `RTAC_DEM_LO_TABLE;
            if (code == 3'h0)
                deemph_decode = 8'h00; // see RULE7
            else
                deemph_decode = tab[8*(code-3'h1) +: 8]; // see RULE6
        end
    endfunction

    // Table address test
    function in_table;
        input [7:0] a;
        begin
            in_table = (a >= `RTAC_OFF_TABLE_FIRST) &&
                       (a <= `RTAC_OFF_TABLE_LAST);
        end
    endfunction

    // ----------------------------------------
    // Shared channel select register
    // ----------------------------------------
    reg  [7:0] chan_sel_q;
    wire [1:0] sel_ch    = chan_sel_q[`RTAC_SEL_MSB:0];
    wire       chan_mode = chan_sel_q[`RTAC_BIT_CHAN_REGS];
    wire       bcast     = chan_mode & chan_sel_q[`RTAC_BIT_BROADCAST];
    wire       wr_sel    = reg_wr && (reg_addr == `RTAC_OFF_CHAN_SELECT);

    // Select register always takes writes to 0xff
    always @(posedge clk_sys) begin
        if (!reset_n)
            chan_sel_q <= `RTAC_RST_BYTE;
        else if (wr_sel)
            chan_sel_q <= reg_wdata; // see RULE9
    end

    // ----------------------------------------
    // Per-channel register sets
    // ----------------------------------------
    reg [7:0] emph_q  [0:NUM_CH-1];
    reg [7:0] swing_q [0:NUM_CH-1];
    reg [7:0] adapt_q [0:NUM_CH-1];
    reg [7:0] sidx_q  [0:NUM_CH-1];
    reg [7:0] table_q [0:32*NUM_CH-1];

    genvar ch;
    genvar e;
    generate
        for (ch = 0; ch < NUM_CH; ch = ch + 1) begin : g_ch
            // Write hits this channel directly or by broadcast
            wire hit = reg_wr && !wr_sel && chan_mode &&
                       (bcast || sel_ch == ch); // see RULE13 see RULE14
            wire ch_rst = !reset_n || (hit &&
                          reg_addr == `RTAC_OFF_CH_RESET &&
                          reg_wdata[`RTAC_BIT_CH_RESET]); // see RULE12
            wire [4:0] idx_d = adapt_q[ch][`RTAC_BIT_OVERRIDE] ?
                               sidx_q[ch][`RTAC_IDX_MSB:0] : // see RULE2
                               `RTAC_RST_IDX; // see RULE1 see RULE4

            // Control registers
            always @(posedge clk_sys) begin
                if (ch_rst) begin
                    emph_q[ch]  <= `RTAC_RST_BYTE;
                    swing_q[ch] <= `RTAC_RST_BYTE;
                    adapt_q[ch] <= `RTAC_RST_BYTE;
                    sidx_q[ch]  <= `RTAC_RST_BYTE;
                end else if (hit) begin
                    if (reg_addr == `RTAC_OFF_EMPHASIS)
                        emph_q[ch] <= reg_wdata;
                    if (reg_addr == `RTAC_OFF_SWING)
                        swing_q[ch] <= reg_wdata;
                    if (reg_addr == `RTAC_OFF_ADAPT_CTRL)
                        adapt_q[ch] <= reg_wdata;
                    if (reg_addr == `RTAC_OFF_START_IDX)
                        sidx_q[ch] <= reg_wdata;
                end
            end

            // Candidate boost table entries
            for (e = 0; e < 32; e = e + 1) begin : g_ent
                always @(posedge clk_sys) begin
                    if (ch_rst)
                        table_q[32*ch+e] <= boost_default(e);
                    else if (hit && reg_addr ==
                             `RTAC_OFF_TABLE_FIRST + e)
                        table_q[32*ch+e] <= reg_wdata;
                end
            end

            // Static decoded outputs
            always @(posedge clk_sys) begin
                if (!reset_n) begin
                    start_index[5*ch +: 5]  <= `RTAC_RST_IDX;
                    start_boost[8*ch +: 8]  <= `RTAC_RST_BYTE;
                    swing_level[8*ch +: 8]  <= `RTAC_SWING_BASE;
                    deemph_level[8*ch +: 8] <= `RTAC_RST_BYTE;
                end else begin
                    start_index[5*ch +: 5]  <= idx_d; // see RULE15
                    start_boost[8*ch +: 8]  <=
                        table_q[32*ch + idx_d]; // see RULE3
                    swing_level[8*ch +: 8]  <= `RTAC_SWING_BASE +
                        `RTAC_SWING_STEP *
                        {5'h00, swing_q[ch][`RTAC_CODE_MSB:0]}; // see RULE5
                    deemph_level[8*ch +: 8] <= deemph_decode(emph_q[ch]);
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    reg [7:0] rd_d;
    always @* begin
        rd_d = `RTAC_RST_BYTE;
        if (reg_addr == `RTAC_OFF_CHAN_SELECT)
            rd_d = chan_sel_q;
        else if (chan_mode) begin
            if (reg_addr == `RTAC_OFF_EMPHASIS)
                rd_d = emph_q[sel_ch];
            else if (reg_addr == `RTAC_OFF_SWING)
                rd_d = swing_q[sel_ch];
            else if (reg_addr == `RTAC_OFF_ADAPT_CTRL)
                rd_d = adapt_q[sel_ch];
            else if (reg_addr == `RTAC_OFF_START_IDX)
                rd_d = sidx_q[sel_ch];
            else if (in_table(reg_addr))
                rd_d = table_q[{sel_ch, reg_addr[4:0]}];
        end
    end

    // Read data register
    always @(posedge clk_sys) begin
        if (!reset_n)
            reg_rdata <= `RTAC_RST_BYTE;
        else if (reg_rd)
            reg_rdata <= rd_d;
    end

endmodule

// ==== tb/rtac_channel_config_sva.sv ====
`timescale 1ns/10ps
module rtac_channel_config_sva #(
    parameter NUM_CH = 4
) (
    input wire                clk_sys,      // Clock
    input wire                reset_n,      // Reset
    input wire                reg_wr,       // Write
    input wire                reg_rd,       // Read
    input wire [7:0]          reg_addr,     // Offset
    input wire [7:0]          reg_wdata,    // Write data
    input wire [7:0]          reg_rdata,    // Read data
    input wire [5*NUM_CH-1:0] start_index,  // Index
    input wire [8*NUM_CH-1:0] start_boost,  // Boost
    input wire [8*NUM_CH-1:0] swing_level,  // Swing
    input wire [8*NUM_CH-1:0] deemph_level  // De-emphasis
);
    reg [7:0] sel_q;  // Select shadow
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // Shadow of the select register
    always @(posedge clk_sys) begin
        if (!reset_n)
            sel_q <= 8'h00;
        else if (reg_wr && reg_addr == 8'hff)
            sel_q <= reg_wdata;
    end
    sequence s_wr0(a);
        reg_wr && reg_addr == a && sel_q[2] && (sel_q[3] || !sel_q[1:0]);
    endsequence
    sequence s_bc(a);
        reg_wr && reg_addr == a && sel_q[3:2] == 2'h3;
    endsequence
    a_swing_write: assert property (s_wr0(8'h2d) |-> ##2
        swing_level[7:0] == 8'h3c + 8'h0a * $past(reg_wdata[2:0], 2))
        else $error("swing level wrong");
    a_deemph_zero: assert property (s_wr0(8'h15) ##0 !reg_wdata[2:0]
        |-> ##2 deemph_level[7:0] == 8'h00) else $error("nonzero dB");
    a_deemph_legal: assert property (deemph_level[7:0] inside {8'h00,
        8'h0f, 8'h14, 8'h23, 8'h2a, 8'h32, 8'h3c, 8'h41, 8'h48, 8'h50,
        8'h5a, 8'h5f, 8'h6e, 8'h82, 8'h96}) else $error("bad dB level");
    a_index_default: assert property (s_wr0(8'h2f) ##0 !reg_wdata[3]
        |-> ##2 start_index[4:0] == 5'h00) else $error("index not zero");
    a_bcast_write: assert property (s_bc(8'h2d) |-> ##2
        swing_level[8*NUM_CH-1 -: 8] == swing_level[7:0])
        else $error("broadcast missed");
    a_levels_static: assert property (!reg_wr [*2] |=>
        $stable(swing_level) && $stable(deemph_level) &&
        $stable(start_index) && $stable(start_boost)) else $error("drift");
    a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved");
    a_sel_readback: assert property (reg_rd && reg_addr == 8'hff
        |=> reg_rdata == $past(sel_q)) else $error("select readback");
    a_shared_read: assert property (reg_rd && reg_addr != 8'hff
        && !sel_q[2] |=> reg_rdata == 8'h00) else $error("shared not 0");
    a_reserved_read: assert property (reg_rd && reg_addr < 8'h15
        |=> reg_rdata == 8'h00) else $error("reserved not 0");
endmodule
bind rtac_channel_config rtac_channel_config_sva #(.NUM_CH(NUM_CH)) u_sva (
    .clk_sys(clk_sys), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .start_index(start_index), .start_boost(start_boost),
    .swing_level(swing_level), .deemph_level(deemph_level));

// ==== tb/rtac_host_model.sv ====
`timescale 1ns/10ps
module rtac_host_model (
    input  wire       clk_sys,   // Clock
    output reg        reg_wr,    // Write
    output reg        reg_rd,    // Read
    output reg  [7:0] reg_addr,  // Offset
    output reg  [7:0] reg_wdata, // Write data
    input  wire [7:0] reg_rdata  // Read data
);
    initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
    // One write; idle lines show the inverse afterwards
    task wr(input [7:0] a, input [7:0] d);
        @(negedge clk_sys);
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(negedge clk_sys);
        {reg_wr, reg_addr, reg_wdata} = {1'b0, ~a, ~d};
    endtask
    task rd(input [7:0] a);
        @(negedge clk_sys);
        {reg_rd, reg_addr} = {1'b1, a};
        @(negedge clk_sys);
        {reg_rd, reg_addr} = {1'b0, ~a};
    endtask
    // Field update keeps the other bits
    task rmw(input [7:0] a, input [7:0] m, input [7:0] d);
        rd(a);
        wr(a, (reg_rdata & ~m) | (d & m));
    endtask
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/10ps
`include "rtac_consts.vh"
module testbench;
    localparam [255:0] BOOST = {64'ha5_96_99_d5_75_69_5d_57,
        64'hc8_b0_8c_52_46_a0_82_88, 64'h90_60_c0_50_41_30_0c_03,
        64'h80_02_08_40_10_04_01_00};
    reg clk_sys = 1'b0;
    reg reset_n = 1'b0;
    reg rd_seen = 1'b0;
    wire reg_wr, reg_rd;
    wire [7:0] reg_addr, reg_wdata, reg_rdata;
    wire [19:0] start_index;
    wire [31:0] start_boost, swing_level, deemph_level;
    int n_errors = 0, samples_checked = 0, cycles = 0, i;
    logic [7:0] exp_q[$];
    logic [7:0] v, e;
    always #20 clk_sys = ~clk_sys;
    rtac_channel_config dut (.clk_sys(clk_sys), .reset_n(reset_n),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .start_index(start_index), .start_boost(start_boost),
        .swing_level(swing_level), .deemph_level(deemph_level));
    rtac_host_model host (.clk_sys(clk_sys), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata));
    task chk(input [7:0] seen, input [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    task tally_and_finish;
        $display("checked %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task rdq(input [7:0] a, input [7:0] x);
        exp_q.push_back(x);
        host.rd(a);
    endtask
    // Write, then wait for the decoded output flop to follow
    task wrw(input [7:0] a, input [7:0] d);
        host.wr(a, d);
        @(negedge clk_sys);
    endtask
    // Read monitor and cycle limit
    always @(posedge clk_sys) begin
        rd_seen <= reg_rd;
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors++;
            tally_and_finish;
        end
    end
    always @(negedge clk_sys) begin
        if (rd_seen)
            chk(reg_rdata, exp_q.pop_front());
    end
    initial begin
        v = $urandom(72654);
        repeat (3) @(negedge clk_sys);
        reset_n = 1'b1;
        @(negedge clk_sys);
        for (i = 0; i < 4; i++) begin
            chk(swing_level[8*i +: 8], 8'h3c);
            chk(deemph_level[8*i +: 8] | start_boost[8*i +: 8], 8'h00);
        end
        host.wr(8'hff, 8'h04);
        for (i = 0; i < 8; i++) begin
            v = ($urandom & 8'hf8) | i[2:0];
            wrw(8'h2d, v);
            chk(swing_level[7:0], 8'h3c + 8'h0a * i[7:0]);
            rdq(8'h2d, v);
        end
        exp_q.push_back(v);
        host.rmw(8'h2d, 8'h07, 8'h02);
        rdq(8'h2d, (v & 8'hf8) | 8'h02);
        $display("test swing done");
        for (i = 0; i < 16; i++) begin
            v = ($urandom & 8'hb8) | {1'b0, i[3], 3'h0, i[2:0]};
            e = !i[2:0] ? 8'h00 : i[3] ? `RTAC_DEM_HI_TABLE >> 8*i[2:0]-8
                : `RTAC_DEM_LO_TABLE >> 8*i[2:0]-8;
            wrw(8'h15, v);
            chk(deemph_level[7:0], e);
        end
        $display("test deemph done");
        host.wr(8'h39, 8'h1b);
        wrw(8'h2f, 8'h08);
        chk({3'h0, start_index[4:0]}, 8'h1b);
        wrw(8'h2f, $urandom & 8'hf7);
        chk({3'h0, start_index[4:0]}, 8'h00);
        host.wr(8'h2f, 8'h08);
        for (i = 0; i < 32; i++) begin
            wrw(8'h39, ($urandom & 8'he0) | i[4:0]);
            chk({3'h0, start_index[4:0]}, i[7:0]);
            chk(start_boost[7:0], BOOST[8*i +: 8]);
        end
        v = $urandom & 8'h5a;
        wrw(8'h5f, v);
        chk(start_boost[7:0], v);
        host.wr(8'h00, 8'h04);
        host.wr(8'h2f, 8'h08);
        wrw(8'h39, 8'h1f);
        chk(start_boost[7:0], 8'ha5);
        $display("test index done");
        host.wr(8'hff, 8'h05);
        wrw(8'h2d, 8'h03);
        chk(swing_level[15:8], 8'h5a);
        chk(swing_level[7:0], 8'h3c);
        host.wr(8'hff, 8'h0c);
        wrw(8'h2d, 8'h05);
        for (i = 0; i < 4; i++) chk(swing_level[8*i +: 8], 8'h6e);
        rdq(8'hff, 8'h0c);
        host.wr(8'hff, 8'h00);
        host.wr(8'h2d, 8'h07);
        rdq(8'h2d, 8'h00);
        host.wr(8'hff, 8'h04);
        rdq(8'h2d, 8'h05);
        rdq(8'h10, 8'h00);
        $display("test routing done");
        repeat (2) @(negedge clk_sys);
        tally_and_finish;
    end
endmodule
